// >>> include/rftx_pkg.sv
// Purpose: Shared constants and types of the transmitter configuration block.
// Assumes: Registers sit one per 32-bit word; byte address is four times the index.
// Notes:   Reset values and style codes are plain defaults held here once.
package rftx_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int unsigned RFTX_ADDR_W   = 12;
	localparam logic [7:0] IDX_DRIVER_MODE       = 8'h28;
	localparam logic [7:0] IDX_CARRIER_AMPLITUDE = 8'h29;
	localparam logic [7:0] IDX_MODULATION_CTRL   = 8'h2a;
	localparam logic [7:0] IDX_OVERSHOOT_LOAD    = 8'h2b;
	localparam logic [1:0] WORD_LSBS             = 2'h0;

	// Reset values and writable-bit masks (reserved bits stay zero).
	localparam logic [7:0] RST_DRIVER_MODE  = 8'h00;
	localparam logic [7:0] RST_CARRIER_AMP  = 8'h00;
	localparam logic [7:0] RST_MOD_CTRL     = 8'h00;
	localparam logic [7:0] RST_OVERSHOOT    = 8'h00;
	localparam logic [7:0] MASK_DRIVER_MODE = 8'hcf;
	localparam logic [7:0] MASK_CARRIER_AMP = 8'hdf;
	localparam logic [7:0] MASK_MOD_CTRL    = 8'hff;
	localparam logic [7:0] MASK_OVERSHOOT   = 8'hff;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int unsigned POS_SECOND_INV = 7;
	localparam int unsigned POS_FIRST_INV  = 6;
	localparam int unsigned POS_DRV_EN     = 3;
	localparam int unsigned POS_FULL_SWING = 3;
	localparam int unsigned POS_MOD_INV    = 2;

	typedef enum logic [2:0] {
		STYLE_HIGH_Z     = 3'h0,
		STYLE_PUSH_PULL  = 3'h1,
		STYLE_OPEN_DRAIN = 3'h2,
		STYLE_BAD_A      = 3'h3,
		STYLE_FIXED_LOW  = 3'h4,
		STYLE_FIXED_HIGH = 3'h5,
		STYLE_BAD_B      = 3'h6,
		STYLE_PUSH_ALT   = 3'h7
	} rftx_style_type;

	typedef enum logic [1:0] {
		MSRC_NONE     = 2'h0,
		MSRC_ENVELOPE = 2'h1,
		MSRC_EXTERNAL = 2'h2,
		MSRC_RESERVED = 2'h3
	} rftx_msrc_type;

	typedef struct packed {
		logic           second_driver_invert;
		logic           first_driver_invert;
		logic           driver_enable;
		rftx_style_type driver_output_style;
		logic [1:0]     carrier_level_reduction;
		logic [4:0]     residual_carrier;
		logic [3:0]     overshoot_extra_length;
		logic           full_swing;
		logic           modulation_polarity_flip;
		rftx_msrc_type  modulation_source_select;
		logic [3:0]     overshoot_first_timer_value;
		logic [3:0]     expected_load_current_trim;
	} rftx_cfg_type;

	typedef struct packed {
		logic out;
		logic oe;
	} rftx_pin_type;

endpackage

// >>> hw/rftx_config_regs.sv
// Purpose: Transmitter configuration registers on APB and the driver pin logic they steer.
// Assumes: One clock pclk at 25 MHz; asynchronous active-low reset presetn.
// Notes:   Zero-wait APB slave; unmapped addresses answer with pslverr.
`timescale 1ns/1ps

// How it works
// R1 - Bit 7 inverts second antenna driver pin
// R2 - Bit 6 inverts first antenna driver pin
// R3 - Bit 3 enables both driver pins together
// R4 - Software avoids the two unsupported style codes
// R5 - Style field picks open-drain, push-pull, off, fixed
// R6 - Two bits pick 100/250/500/1000 mV reduction
// R7 - Full swing forces maximum, ignores reduction
// R8 - Source: none, envelope, external, reserved
// R9 - Polarity bit inverts chosen modulation signal
// R10 - Extra overshoot modulation length in carrier cycles
// R11 - Load register upper nibble feeds first timer
// R12 - Lower nibble holds expected load current trim
// R13 - Five bits hold residual carrier percentage
// R14 - Reserved bits read zero, writes ignored
module rftx_config_regs
	import rftx_pkg::*;
#(
	parameter int unsigned CARRIER_DIV = 2
) (
	// Clock and reset
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	// APB slave
	input  wire logic [RFTX_ADDR_W-1:0] paddr,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [31:0]            pwdata,
	input  wire logic [3:0]             pstrb,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	// Modulation sources
	input  wire logic                   internal_envelope,
	input  wire logic                   ext_modulation_pin,
	// Antenna driver pins
	output rftx_pin_type                first_antenna_driver_pin,
	output rftx_pin_type                second_antenna_driver_pin,
	// Analog control
	output logic                        full_swing_active,
	output logic [1:0]                  amplitude_reduction_sel,
	output logic                        modulation_active,
	output rftx_cfg_type                cfg
);

	// ----------------------------------------------------------------
	// Register storage and APB decode
	// ----------------------------------------------------------------
	logic [7:0] driver_mode_r;
	logic [7:0] carrier_amplitude_r;
	logic [7:0] modulation_control_r;
	logic [7:0] overshoot_load_trim_r;
	logic [31:0] prdata_r;
	logic        pslverr_r;

	function automatic logic [RFTX_ADDR_W-1:0] byte_addr(input logic [7:0] idx);
		byte_addr = {{(RFTX_ADDR_W-10){1'b0}}, idx, WORD_LSBS};
	endfunction

	function automatic logic hit(input logic [RFTX_ADDR_W-1:0] a);
		hit = (a == byte_addr(IDX_DRIVER_MODE)) || (a == byte_addr(IDX_CARRIER_AMPLITUDE)) ||
		      (a == byte_addr(IDX_MODULATION_CTRL)) || (a == byte_addr(IDX_OVERSHOOT_LOAD));
	endfunction

	logic wr_en;
	logic setup;
	assign setup  = psel && !penable;
	assign wr_en  = psel && penable && pwrite && pready && pstrb[0];
	assign pready = 1'b1;
	assign prdata = prdata_r;
	assign pslverr = pslverr_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			driver_mode_r         <= RST_DRIVER_MODE;
			carrier_amplitude_r   <= RST_CARRIER_AMP;
			modulation_control_r  <= RST_MOD_CTRL;
			overshoot_load_trim_r <= RST_OVERSHOOT;
		end else if (wr_en) begin
			// Reserved positions are masked away on write. [R14]
			if (paddr == byte_addr(IDX_DRIVER_MODE))
				driver_mode_r <= pwdata[7:0] & MASK_DRIVER_MODE;
			if (paddr == byte_addr(IDX_CARRIER_AMPLITUDE))
				carrier_amplitude_r <= pwdata[7:0] & MASK_CARRIER_AMP;
			if (paddr == byte_addr(IDX_MODULATION_CTRL))
				modulation_control_r <= pwdata[7:0] & MASK_MOD_CTRL;
			if (paddr == byte_addr(IDX_OVERSHOOT_LOAD))
				overshoot_load_trim_r <= pwdata[7:0] & MASK_OVERSHOOT;
		end
	end

	// Read data and error are captured in the setup cycle so the access phase sees flip-flops.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r  <= 32'h0000_0000;
			pslverr_r <= 1'b0;
		end else if (setup) begin
			pslverr_r <= !hit(paddr);
			if (pwrite || !hit(paddr))
				prdata_r <= 32'h0000_0000;
			else if (paddr == byte_addr(IDX_DRIVER_MODE))
				prdata_r <= {24'h00_0000, driver_mode_r};
			else if (paddr == byte_addr(IDX_CARRIER_AMPLITUDE))
				prdata_r <= {24'h00_0000, carrier_amplitude_r};
			else if (paddr == byte_addr(IDX_MODULATION_CTRL))
				prdata_r <= {24'h00_0000, modulation_control_r};
			else
				prdata_r <= {24'h00_0000, overshoot_load_trim_r};
		end
	end

	// ----------------------------------------------------------------
	// Field decode
	// ----------------------------------------------------------------
	always_comb begin
		cfg.second_driver_invert        = driver_mode_r[POS_SECOND_INV];                         // [R1]
		cfg.first_driver_invert         = driver_mode_r[POS_FIRST_INV];                          // [R2]
		cfg.driver_enable               = driver_mode_r[POS_DRV_EN];                             // [R3]
		cfg.driver_output_style         = rftx_style_type'(driver_mode_r[2:0]);                  // [R5]
		cfg.carrier_level_reduction     = carrier_amplitude_r[7:6];                              // [R6]
		cfg.residual_carrier            = carrier_amplitude_r[4:0];                              // [R13]
		cfg.overshoot_extra_length      = modulation_control_r[7:4];                             // [R10]
		cfg.full_swing                  = modulation_control_r[POS_FULL_SWING];                  // [R7]
		cfg.modulation_polarity_flip    = modulation_control_r[POS_MOD_INV];                     // [R9]
		cfg.modulation_source_select    = rftx_msrc_type'(modulation_control_r[1:0]);            // [R8]
		cfg.overshoot_first_timer_value = overshoot_load_trim_r[7:4];                            // [R11]
		cfg.expected_load_current_trim  = overshoot_load_trim_r[3:0];                            // [R12]
	end

	// Full swing overrides the reduction choice; the selector then reads zero. [R7] [R6]
	assign full_swing_active       = cfg.full_swing;
	assign amplitude_reduction_sel = cfg.full_swing ? 2'h0 : cfg.carrier_level_reduction;

	// ----------------------------------------------------------------
	// External modulation synchroniser and carrier divider
	// ----------------------------------------------------------------
	logic ext_sync1_r;
	logic ext_sync2_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_sync1_r <= 1'b0;
			ext_sync2_r <= 1'b0;
		end else begin
			ext_sync1_r <= ext_modulation_pin;
			ext_sync2_r <= ext_sync1_r;
		end
	end

	localparam int unsigned DIV_W = (CARRIER_DIV > 1) ? $clog2(CARRIER_DIV) : 1;
	logic [DIV_W-1:0] div_cnt_r;
	logic             carrier_tick;
	logic             carrier_phase_r;
	assign carrier_tick = (div_cnt_r == DIV_W'(CARRIER_DIV - 1));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			div_cnt_r <= '0;
		else if (carrier_tick)
			div_cnt_r <= '0;
		else
			div_cnt_r <= div_cnt_r + DIV_W'(1);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			carrier_phase_r <= 1'b0;
		else if (carrier_tick)
			carrier_phase_r <= !carrier_phase_r;
	end

	// One carrier cycle ends on the tick that returns the phase to low.
	logic carrier_cycle_end;
	assign carrier_cycle_end = carrier_tick && carrier_phase_r;

	// ----------------------------------------------------------------
	// Modulation source and overshoot extension
	// ----------------------------------------------------------------
	logic mod_raw;
	always_comb begin
		case (cfg.modulation_source_select)                                                     // [R8]
			MSRC_ENVELOPE: mod_raw = internal_envelope;
			MSRC_EXTERNAL: mod_raw = ext_sync2_r;
			default:       mod_raw = 1'b0;
		endcase
	end

	logic mod_sel;
	assign mod_sel = (cfg.modulation_source_select == MSRC_ENVELOPE ||
	                  cfg.modulation_source_select == MSRC_EXTERNAL) ?
	                 (mod_raw ^ cfg.modulation_polarity_flip) : 1'b0;                             // [R9]

	typedef enum logic [2:0] {
		OS_IDLE  = 3'b001,
		OS_MOD   = 3'b010,
		OS_EXTRA = 3'b100
	} rftx_os_state_type;

	rftx_os_state_type os_state_r;
	logic [3:0]        extra_cnt_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			os_state_r  <= OS_IDLE;
			extra_cnt_r <= 4'h0;
		end else begin
			case (os_state_r)
				OS_IDLE: begin
					if (mod_sel)
						os_state_r <= OS_MOD;
				end
				OS_MOD: begin
					// Modulation is held for the programmed number of extra carrier cycles. [R10]
					if (!mod_sel && cfg.overshoot_extra_length != 4'h0) begin
						os_state_r  <= OS_EXTRA;
						extra_cnt_r <= cfg.overshoot_extra_length;
					end else if (!mod_sel) begin
						os_state_r <= OS_IDLE;
					end
				end
				OS_EXTRA: begin
					if (mod_sel) begin
						os_state_r <= OS_MOD;
					end else if (carrier_cycle_end) begin
						extra_cnt_r <= extra_cnt_r - 4'h1;
						if (extra_cnt_r == 4'h1)
							os_state_r <= OS_IDLE;
					end
				end
				default: os_state_r <= OS_IDLE;
			endcase
		end
	end

	assign modulation_active = (os_state_r == OS_MOD) || (os_state_r == OS_EXTRA);

	// ----------------------------------------------------------------
	// Driver pin style
	// ----------------------------------------------------------------
	function automatic rftx_pin_type drive(input rftx_style_type st, input logic en, input logic lvl);
		drive = '{out: 1'b0, oe: 1'b0};
		if (en) begin                                                                             // [R3]
			case (st)                                                                             // [R5]
				STYLE_PUSH_PULL,
				STYLE_PUSH_ALT:   drive = '{out: lvl, oe: 1'b1};
				STYLE_OPEN_DRAIN: drive = '{out: 1'b0, oe: !lvl};
				STYLE_FIXED_LOW:  drive = '{out: 1'b0, oe: 1'b1};
				STYLE_FIXED_HIGH: drive = '{out: 1'b1, oe: 1'b1};
				default:          drive = '{out: 1'b0, oe: 1'b0};
			endcase
		end
	endfunction

	rftx_pin_type first_pin_r;
	rftx_pin_type second_pin_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			first_pin_r  <= '{out: 1'b0, oe: 1'b0};
			second_pin_r <= '{out: 1'b0, oe: 1'b0};
		end else begin
			first_pin_r  <= drive(cfg.driver_output_style, cfg.driver_enable,
			                      carrier_phase_r ^ cfg.first_driver_invert);                     // [R2]
			second_pin_r <= drive(cfg.driver_output_style, cfg.driver_enable,
			                      carrier_phase_r ^ cfg.second_driver_invert);                    // [R1]
		end
	end

	assign first_antenna_driver_pin  = first_pin_r;
	assign second_antenna_driver_pin = second_pin_r;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence push_pull_cfg;
		cfg.driver_enable && cfg.driver_output_style == STYLE_PUSH_PULL;
	endsequence

	second_inv_a: assert property (push_pull_cfg ##1 push_pull_cfg |->      // [R1]
		second_antenna_driver_pin.out == ($past(carrier_phase_r) ^ $past(cfg.second_driver_invert)))
		else $error("second driver pin polarity wrong");

	first_inv_a: assert property (push_pull_cfg ##1 push_pull_cfg |->       // [R2]
		first_antenna_driver_pin.out == ($past(carrier_phase_r) ^ $past(cfg.first_driver_invert)))
		else $error("first driver pin polarity wrong");

	driver_disable_a: assert property (!cfg.driver_enable |=>               // [R3]
		!first_antenna_driver_pin.oe && !second_antenna_driver_pin.oe)
		else $error("driver pins enabled while disabled");

	fixed_high_a: assert property (cfg.driver_enable && cfg.driver_output_style == STYLE_FIXED_HIGH |=>  // [R5]
		first_antenna_driver_pin.out && first_antenna_driver_pin.oe && second_antenna_driver_pin.out)
		else $error("fixed high style not driven");

	full_swing_a: assert property (cfg.full_swing |-> amplitude_reduction_sel == 2'h0 && full_swing_active)  // [R7]
		else $error("full swing not overriding reduction");

	no_mod_src_a: assert property (cfg.modulation_source_select == MSRC_NONE [*3] |->  // [R8]
		os_state_r != OS_MOD)
		else $error("modulation without source");

	extra_len_a: assert property ($rose(os_state_r == OS_EXTRA) |->          // [R10]
		extra_cnt_r == $past(cfg.overshoot_extra_length) && extra_cnt_r != 4'h0)
		else $error("overshoot extension length wrong");

	reserved_zero_a: assert property (wr_en |=>                              // [R14]
		driver_mode_r[5:4] == 2'h0 && carrier_amplitude_r[5] == 1'b0)
		else $error("reserved bit stored");

	read_back_a: assert property (setup && !pwrite && paddr == byte_addr(IDX_OVERSHOOT_LOAD) |=>  // [R11]
		prdata[7:4] == cfg.overshoot_first_timer_value && prdata[31:8] == 24'h00_0000)
		else $error("load register read back wrong");

	// Last carrier cycle of an overshoot extension with no new modulation.
	sequence extension_last_step;
		os_state_r == OS_EXTRA && !mod_sel && carrier_cycle_end && extra_cnt_r == 4'h1;
	endsequence

	extra_end_a: assert property (extension_last_step |=>                   // [R10]
		os_state_r == OS_IDLE)
		else $error("overshoot extension overran");

	mod_start_a: assert property (mod_sel |=>                               // [R8]
		os_state_r == OS_MOD && modulation_active)
		else $error("selected modulation not applied");

	reduction_pass_a: assert property (!cfg.full_swing |->                  // [R6]
		amplitude_reduction_sel == cfg.carrier_level_reduction && !full_swing_active)
		else $error("reduction selector not passed through");

	open_drain_a: assert property (cfg.driver_enable && cfg.driver_output_style == STYLE_OPEN_DRAIN |=>  // [R5]
		!first_antenna_driver_pin.out && !second_antenna_driver_pin.out)
		else $error("open drain pin driven high");

	fixed_low_a: assert property (cfg.driver_enable && cfg.driver_output_style == STYLE_FIXED_LOW |=>  // [R5]
		!first_antenna_driver_pin.out && first_antenna_driver_pin.oe && !second_antenna_driver_pin.out)
		else $error("fixed low style not driven");

endmodule

// >>> verification/rftx_config_regs_bench.sv
// Purpose: Self-checking bench for the transmitter configuration registers.
// Assumes: The APB slave answers in its own time; the bench waits for pready.
// Notes:   A byte model of the four registers predicts every read and field.
`timescale 1ns/1ps
module rftx_config_regs_bench;
	import rftx_pkg::*;
	// ------------------------------------------------------------
	// Signals and model state
	// ------------------------------------------------------------
	logic                   pclk;
	logic                   presetn;
	logic                   psel;
	logic                   penable;
	logic                   pwrite;
	logic                   env;
	logic                   ext;
	logic [RFTX_ADDR_W-1:0] paddr;
	logic [31:0]            pwdata;
	logic [31:0]            prdata;
	logic [31:0]            rd;
	logic [3:0]             pstrb;
	logic                   pready;
	logic                   pslverr;
	logic                   err;
	logic                   fsw;
	logic                   mact;
	logic [1:0]             ared;
	rftx_pin_type           p1;
	rftx_pin_type           p2;
	rftx_cfg_type           cfg;
	int                     n_fail = 0;
	int                     tests_run = 0;
	int                     cyc = 0;
	int                     seed;
	int                     k;
	int                     s;
	int                     lo;
	logic [7:0]             m [4];
	logic [7:0]             msk [4];
	logic [7:0]             v;
	int                     styles [6] = '{0, 1, 2, 4, 5, 7};
	int                     lens [3] = '{0, 3, 15};

	rftx_config_regs #(.CARRIER_DIV(2)) uut (
		.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .internal_envelope(env), .ext_modulation_pin(ext),
		.first_antenna_driver_pin(p1), .second_antenna_driver_pin(p2),
		.full_swing_active(fsw), .amplitude_reduction_sel(ared), .modulation_active(mact), .cfg(cfg));

	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic end_sim();
		$display("Counts: %0d comparisons, %0d mismatches", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// A hung handshake runs into this ceiling.
	always @(posedge pclk) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			end_sim();
		end
	end

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// The wait ends when pready is seen high; only the bench timeout ends a wait in which it never is.
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	function automatic logic [11:0] ad(input int i);
		return 12'((int'(IDX_DRIVER_MODE) + i) * 4);
	endfunction

	task automatic mw(input int i, input logic [7:0] d);
		apb(1'b1, ad(i), {24'h0000_00, d});
		if (pstrb[0]) m[i] = d & msk[i];
	endtask

	task automatic rdc(input int i);
		apb(1'b0, ad(i), 32'h0000_0000);
		chk("read data", {24'h0000_00, m[i]}, rd);
		chk("read error", 32'h0000_0000, err);
	endtask

	task automatic cc();
		chk("second invert", m[0][7], cfg.second_driver_invert);
		chk("first invert", m[0][6], cfg.first_driver_invert);
		chk("driver enable", m[0][3], cfg.driver_enable);
		chk("output style", m[0][2:0], cfg.driver_output_style);
		chk("reduction", m[1][7:6], cfg.carrier_level_reduction);
		chk("residual", m[1][4:0], cfg.residual_carrier);
		chk("extra length", m[2][7:4], cfg.overshoot_extra_length);
		chk("full swing", m[2][3], cfg.full_swing);
		chk("polarity", m[2][2], cfg.modulation_polarity_flip);
		chk("source", m[2][1:0], cfg.modulation_source_select);
		chk("first timer", m[3][7:4], cfg.overshoot_first_timer_value);
		chk("load trim", m[3][3:0], cfg.expected_load_current_trim);
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		seed = 32'h6e8e;
		{presetn, psel, penable, pwrite, env, ext} = 6'h00;
		paddr = '0;
		pwdata = 32'h0000_0000;
		pstrb = 4'hf;
		msk = '{MASK_DRIVER_MODE, MASK_CARRIER_AMP, MASK_MOD_CTRL, MASK_OVERSHOOT};
		m = '{8'h00, 8'h00, 8'h00, 8'h00};
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		for (s = 0; s < 4; s++) rdc(s);
		cc();
		$display("Test reset values done");
		mw(0, 8'hff);
		mw(1, 8'hff);
		rdc(0);
		rdc(1);
		repeat (40) begin
			s = {$random(seed)} % 4;
			v = 8'($random(seed));
			// Software never programs the two unsupported style codes.
			if (s == 0 && (v[2:0] == 3'h3 || v[2:0] == 3'h6)) v[2:0] = 3'h1;
			mw(s, v);
			rdc(s);
			cc();
		end
		pstrb <= 4'h0;
		mw(3, 8'h5a);
		pstrb <= 4'hf;
		rdc(3);
		apb(1'b1, 12'h0b0, 32'h0000_00ff);
		chk("unmapped write error", 32'h0000_0001, err);
		apb(1'b0, 12'h0b0, 32'h0000_0000);
		chk("unmapped read error", 32'h0000_0001, err);
		chk("unmapped read data", 32'h0000_0000, rd);
		for (s = 0; s < 4; s++) rdc(s);
		$display("Test register access done");
		for (s = 0; s < 8; s++) begin
			mw(1, {2'(s), 6'h15});
			mw(2, {4'h0, s[2], 3'h0});
			// Let the write land before looking at the outputs.
			#1;
			chk("full swing out", s[2], fsw);
			chk("reduction out", s[2] ? 2'h0 : 2'(s), ared);
		end
		$display("Test amplitude done");
		mw(2, 8'h00);
		for (s = 0; s < 12; s++) begin
			v = (8'($random(seed)) & 8'hc0) | (s < 6 ? 8'h08 : 8'h00) | 8'(styles[s % 6]);
			mw(0, v);
			repeat (3) @(posedge pclk);
			#1;
			if (!v[3] || v[2:0] == 3'h0) begin
				chk("driver oe off", 2'h0, {p1.oe, p2.oe});
			end else if (v[2:0] == 3'h4 || v[2:0] == 3'h5) begin
				chk("fixed pins", {2'h3, v[0], v[0]}, {p1.oe, p2.oe, p1.out, p2.out});
			end else if (v[2:0] != 3'h2) begin
				chk("push oe", 2'h3, {p1.oe, p2.oe});
				chk("pin inversion", p1.out ^ v[6] ^ v[7], p2.out);
			end else begin
				chk("open drain", {2'h0, v[6] ^ v[7]}, {p1.out, p2.out, p1.oe ^ p2.oe});
			end
		end
		$display("Test driver pins done");
		for (s = 0; s < 16; s++) begin
			mw(2, {5'h00, s[3], s[1:0]});
			env <= s[2];
			ext <= ~s[2];
			repeat (20) @(posedge pclk);
			#1;
			v = (s[1:0] == 2'h1) ? {7'h0, s[2]} : (s[1:0] == 2'h2) ? {7'h0, ~s[2]} : 8'h00;
			if (s[1:0] == 2'h1 || s[1:0] == 2'h2) v[0] = v[0] ^ s[3];
			chk("modulation", v, mact);
		end
		$display("Test modulation source done");
		for (s = 0; s < 3; s++) begin
			mw(2, {4'(lens[s]), 4'h1});
			env <= 1'b0;
			repeat (80) @(posedge pclk);
			env <= 1'b1;
			repeat (10) @(posedge pclk);
			env <= 1'b0;
			k = 0;
			do begin
				@(posedge pclk);
				#1;
				k++;
			end while (mact === 1'b1 && k < 100);
			lo = lens[s] > 0 ? (lens[s] - 1) * 4 : 0;
			chk("overshoot length", 1, k >= lo && k <= lens[s] * 4 + 6);
		end
		$display("Test overshoot done");
		end_sim();
	end
endmodule
